// *** shared/slpt_pkg.sv ***
package slpt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned DATA_W = 16;               // Data word and address width
  localparam int unsigned PC_W   = 23;               // Program counter width
  localparam int unsigned PAGE_W = 9;                // Page register width
  localparam int unsigned EXT_W  = 24;               // Extended address width
  localparam int unsigned PC_HI_LSB = 16;            // First counter bit of the upper push word

  ////////////////////////////////////////////////////////////////////////////
  // Address constants
  localparam logic [15:0] SP_STEP       = 16'h0002;  // One stack word in bytes
  localparam logic [15:0] SP_RESET      = 16'h0800;  // Pointer after reset, lowest legal stack word
  localparam logic [15:0] UNDERFLOW_LIM = 16'h0800;  // Below this the special register area lies
  localparam logic [15:0] PAGED_BASE    = 16'h8000;  // At or above this the page registers apply
  localparam logic [8:0]  PAGE_NONE     = 9'h000;    // Page value that marks an invalid access
  localparam logic [7:0]  NEAR_UPPER    = 8'h00;     // Upper byte of a near extended address
  localparam logic [7:0]  CALL_UPPER    = 8'h00;     // Upper byte of a call push, zero-extended
  localparam int unsigned ALIGN_BIT     = 0;         // Bit forced to zero for word alignment
  localparam int unsigned OFFSET_MSB    = 14;        // Top offset bit kept inside a page

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic {
    OP_PUSH = 1'b0,                                  // Write, then increment
    OP_POP  = 1'b1                                   // Decrement, then read
  } slpt_op_t;

  typedef enum logic [1:0] {
    KIND_DATA = 2'b00,                               // Single data word
    KIND_CALL = 2'b01,                               // Counter push from a call
    KIND_EXC  = 2'b10                                // Counter push from exception entry
  } slpt_kind_t;

  typedef enum logic {
    ST_IDLE  = 1'b0,                                 // Ready for a request
    ST_PC_HI = 1'b1                                  // Second word of a counter push
  } slpt_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       valid;                               // Request strobe
    slpt_op_t   op;                                  // Push or pop
    slpt_kind_t kind;                                // What a push carries
    logic [15:0] data;                               // Data word for a data push
    logic [22:0] pc;                                 // Counter for a counter push
    logic [7:0] status_low;                          // Status low byte for exception push
  } slpt_stk_req_t;

  typedef struct packed {
    logic       valid;                               // Effective address strobe
    logic       is_write;                            // Destination when set, source otherwise
    logic       uses_sp;                             // Pointer is the stack pointer register
    logic [15:0] addr;                               // Effective address
    logic [8:0] read_page;                           // Read page register value
    logic [8:0] write_page;                          // Write page register value
  } slpt_ea_req_t;

  typedef struct packed {
    logic       valid;                               // Load strobe
    logic [15:0] value;                              // New value
  } slpt_load_t;

endpackage

// *** rtl/slpt_limit_reg.sv ***
`timescale 1ns/10ps
module slpt_limit_reg #(
  parameter int unsigned WIDTH = 16                  // Limit register width
) (
  input  wire logic             i_clk,               // Core clock
  input  wire logic             i_we,                // Write strobe
  input  wire logic [WIDTH-1:0] i_wdata,             // Write data
  output logic      [WIDTH-1:0] o_limit              // Stored limit, word aligned
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage with no reset: software must load it before relying on it
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      o_limit <= {i_wdata[WIDTH-1:1], 1'b0};
    end
  end

endmodule // slpt_limit_reg

// *** rtl/slpt_page_xlat.sv ***
`timescale 1ns/10ps
module slpt_page_xlat (
  input  wire logic [15:0] i_addr,                   // Indirect address
  input  wire logic        i_is_write,               // Selects the write page
  input  wire logic [8:0]  i_read_page,              // Read page register
  input  wire logic [8:0]  i_write_page,             // Write page register
  output logic             o_near,                   // Access stays in near space
  output logic             o_err,                    // Invalid page, address error
  output logic [23:0]      o_ext_addr                // Extended address
);

  logic [8:0] page;                                  // Page that applies to this access

  ////////////////////////////////////////////////////////////////////////////
  // Page selection and address forming
  always_comb begin
    page       = i_is_write ? i_write_page : i_read_page;
    o_near     = (i_addr < slpt_pkg::PAGED_BASE);
    o_err      = 1'b0;
    o_ext_addr = {slpt_pkg::NEAR_UPPER, i_addr};
    if (o_near) begin
      // Pages ignored below the paged window
      o_ext_addr = {slpt_pkg::NEAR_UPPER, i_addr};
    end else if (page == slpt_pkg::PAGE_NONE) begin
      o_err = 1'b1;
    end else begin
      o_ext_addr = {page, i_addr[slpt_pkg::OFFSET_MSB:0]};
    end
  end

endmodule // slpt_page_xlat

// *** rtl/slpt_top.sv ***
// Function
// - Pointer addresses next free word, grows upward
// - Pop predecrements then reads; push writes then increments
// - Call counter push zero-extends upper byte
// - Exception push merges status low byte upward
// - Stack limit register has no reset value
// - Limit bit zero reads zero once the limit has been loaded
// - Stack pointer addresses compared against limit
// - Push at limit passes, next push traps
// - Pointer below 0800h raises underflow stack trap
// - Below 8000h page registers ignored, near access
// - Paged address with zero page: address trap
`timescale 1ns/10ps
module slpt_top (
  input  wire logic                   I_CLK,             // Core clock, 100 MHz
  input  wire logic                   I_ARST_N,          // Asynchronous reset, active low
  input  wire slpt_pkg::slpt_load_t   I_SP_LOAD,         // Working-register write of the pointer
  input  wire slpt_pkg::slpt_load_t   I_LIMIT_LOAD,      // Write of the stack limit register
  input  wire slpt_pkg::slpt_stk_req_t I_STK_REQ,        // Push or pop request
  input  wire slpt_pkg::slpt_ea_req_t I_EA_REQ,          // Indirect address to check
  output logic [15:0]                 O_SP,              // Stack pointer register
  output logic [15:0]                 O_LIMIT,           // Stack limit register
  output logic                        O_BUSY,            // Counter push in progress
  output logic                        O_MEM_WE,          // Stack memory write strobe
  output logic                        O_MEM_RE,          // Stack memory read strobe
  output logic [15:0]                 O_MEM_ADDR,        // Stack memory address
  output logic [15:0]                 O_MEM_WDATA,       // Stack memory write data
  output logic                        O_STACK_ERR,       // Stack error trap pulse
  output logic                        O_STACK_UNDERFLOW, // Underflow cause, with the trap pulse
  output logic                        O_EA_VALID,        // Extended address result strobe
  output logic                        O_EA_NEAR,         // Result lies in near space
  output logic [23:0]                 O_EA_ADDR,         // Extended address result
  output logic                        O_ADDR_ERR         // Address error trap pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  slpt_pkg::slpt_state_t state_reg;                  // Sequencer state
  slpt_pkg::slpt_state_t state_next;                 // Next sequencer state
  logic [15:0]           sp_reg;                     // Stack pointer register
  logic [15:0]           sp_next;                    // Next stack pointer
  logic [15:0]           hi_word_reg;                // Upper counter word waiting
  logic [15:0]           hi_word_next;               // Next upper counter word
  logic [15:0]           limit;                      // Limit, from the storage module
  logic [15:0]           pop_ea;                     // Address a pop would read
  logic [15:0]           push_word;                  // Word written by the first push cycle
  logic                  mem_we_next;                // Next write strobe
  logic                  mem_re_next;                // Next read strobe
  logic [15:0]           mem_addr_next;              // Next memory address
  logic [15:0]           mem_wdata_next;             // Next write data
  logic                  stk_err_next;               // Next stack error pulse
  logic                  stk_unf_next;               // Next underflow cause
  logic                  ea_over;                    // Checked address above the limit
  logic                  ea_under;                   // Checked address below the floor
  logic                  xl_near;                    // Translator near flag
  logic                  xl_err;                     // Translator error flag
  logic [23:0]           xl_addr;                    // Translator address
  logic [15:0]           call_hi;                    // Upper word of a call push
  logic [15:0]           exc_hi;                     // Upper word of an exception push

  ////////////////////////////////////////////////////////////////////////////
  // Limit storage, left unreset on purpose
  slpt_limit_reg #(
    .WIDTH   (slpt_pkg::DATA_W)
  ) u_limit (
    .i_clk   (I_CLK),
    .i_we    (I_LIMIT_LOAD.valid),
    .i_wdata (I_LIMIT_LOAD.value),
    .o_limit (limit)
  );

  // Limit readback straight from the storage flop
  assign O_LIMIT = limit;

  ////////////////////////////////////////////////////////////////////////////
  // Page check of indirect addresses
  slpt_page_xlat u_xlat (
    .i_addr       (I_EA_REQ.addr),
    .i_is_write   (I_EA_REQ.is_write),
    .i_read_page  (I_EA_REQ.read_page),
    .i_write_page (I_EA_REQ.write_page),
    .o_near       (xl_near),
    .o_err        (xl_err),
    .o_ext_addr   (xl_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter push words
  always_comb begin
    // Call pushes keep the upper byte clear
    call_hi = {slpt_pkg::CALL_UPPER, 1'b0,
               I_STK_REQ.pc[slpt_pkg::PC_W-1:slpt_pkg::PC_HI_LSB]};
    // Exception entry folds the status low byte into the upper byte
    exc_hi  = {I_STK_REQ.status_low, 1'b0,
               I_STK_REQ.pc[slpt_pkg::PC_W-1:slpt_pkg::PC_HI_LSB]};
    // Low counter word goes first, data word otherwise
    if (I_STK_REQ.kind == slpt_pkg::KIND_DATA) begin
      push_word = I_STK_REQ.data;
    end else begin
      push_word = I_STK_REQ.pc[slpt_pkg::PC_HI_LSB-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks of addresses that a foreign instruction forms from the pointer
  always_comb begin
    // Above the limit means past the last allowed word
    ea_over  = I_EA_REQ.valid && I_EA_REQ.uses_sp && (I_EA_REQ.addr > limit);
    // Floor protects the special register area
    ea_under = I_EA_REQ.valid && I_EA_REQ.uses_sp &&
               (I_EA_REQ.addr < slpt_pkg::UNDERFLOW_LIM);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack sequencer, next-state logic
  always_comb begin
    state_next     = state_reg;
    sp_next        = sp_reg;
    hi_word_next   = hi_word_reg;
    mem_we_next    = 1'b0;
    mem_re_next    = 1'b0;
    mem_addr_next  = O_MEM_ADDR;
    mem_wdata_next = O_MEM_WDATA;
    stk_err_next   = ea_over || ea_under;
    stk_unf_next   = ea_under;
    pop_ea         = sp_reg - slpt_pkg::SP_STEP;
    case (state_reg)
      slpt_pkg::ST_IDLE: begin
        if (I_SP_LOAD.valid) begin
          // Working-register write wins; a stack request this cycle is dropped
          sp_next = {I_SP_LOAD.value[15:1], 1'b0};
        end else if (I_STK_REQ.valid && I_STK_REQ.op == slpt_pkg::OP_PUSH) begin
          if (sp_reg < slpt_pkg::UNDERFLOW_LIM) begin
            // Pointer sits in the protected area: no write
            stk_err_next = 1'b1;
            stk_unf_next = 1'b1;
          end else if (sp_reg > limit) begin
            // Equal to the limit still passes; one step beyond traps
            stk_err_next = 1'b1;
          end else begin
            // Write at the free word, then step up
            mem_we_next    = 1'b1;
            mem_addr_next  = sp_reg;
            mem_wdata_next = push_word;
            sp_next        = sp_reg + slpt_pkg::SP_STEP;
            if (I_STK_REQ.kind == slpt_pkg::KIND_EXC) begin
              hi_word_next = exc_hi;
              state_next   = slpt_pkg::ST_PC_HI;
            end else if (I_STK_REQ.kind == slpt_pkg::KIND_CALL) begin
              hi_word_next = call_hi;
              state_next   = slpt_pkg::ST_PC_HI;
            end
          end
        end else if (I_STK_REQ.valid) begin
          if (pop_ea < slpt_pkg::UNDERFLOW_LIM) begin
            // Pop would read below the floor
            stk_err_next = 1'b1;
            stk_unf_next = 1'b1;
          end else begin
            // Step down first, then read the word just left
            sp_next       = pop_ea;
            mem_re_next   = 1'b1;
            mem_addr_next = pop_ea;
          end
        end
      end
      slpt_pkg::ST_PC_HI: begin
        // Second word is checked against the limit only, with no underflow check
        state_next = slpt_pkg::ST_IDLE;
        if (sp_reg > limit) begin
          stk_err_next = 1'b1;
        end else begin
          mem_we_next    = 1'b1;
          mem_addr_next  = sp_reg;
          mem_wdata_next = hi_word_reg;
          sp_next        = sp_reg + slpt_pkg::SP_STEP;
        end
      end
      default: begin
        state_next = slpt_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and pointer
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_reg   <= slpt_pkg::ST_IDLE;
      sp_reg      <= slpt_pkg::SP_RESET;
      hi_word_reg <= 16'h0000;
    end else begin
      state_reg   <= state_next;
      sp_reg      <= sp_next;
      hi_word_reg <= hi_word_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack memory port, registered
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_MEM_WE    <= 1'b0;
      O_MEM_RE    <= 1'b0;
      O_MEM_ADDR  <= 16'h0000;
      O_MEM_WDATA <= 16'h0000;
    end else begin
      O_MEM_WE    <= mem_we_next;
      O_MEM_RE    <= mem_re_next;
      O_MEM_ADDR  <= mem_addr_next;
      O_MEM_WDATA <= mem_wdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Visible pointer and busy flag
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SP   <= slpt_pkg::SP_RESET;
      O_BUSY <= 1'b0;
    end else begin
      O_SP   <= sp_next;
      // Busy tracks the state about to be entered, so no request is lost
      O_BUSY <= (state_next != slpt_pkg::ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack trap pulses
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_STACK_ERR       <= 1'b0;
      O_STACK_UNDERFLOW <= 1'b0;
    end else begin
      // A push or pointer check in the same cycle as a limit write is compared with the old limit
      O_STACK_ERR       <= stk_err_next;
      O_STACK_UNDERFLOW <= stk_unf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extended address result and address trap
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_EA_VALID <= 1'b0;
      O_EA_NEAR  <= 1'b0;
      O_EA_ADDR  <= 24'h000000;
      O_ADDR_ERR <= 1'b0;
    end else begin
      // Valid only for an address that will really be used
      O_EA_VALID <= I_EA_REQ.valid && !xl_err;
      O_ADDR_ERR <= I_EA_REQ.valid && xl_err;
      if (I_EA_REQ.valid) begin
        O_EA_NEAR <= xl_near;
        O_EA_ADDR <= xl_addr;
      end
    end
  end

endmodule // slpt_top

// *** dv/slpt_top_assertions.sv ***
`timescale 1ns/10ps
// Watches the top ports only; stack strobes, traps and page math
module slpt_top_assertions (
  input wire logic                    I_CLK,
  input wire logic                    I_ARST_N,
  input wire slpt_pkg::slpt_load_t    I_SP_LOAD,
  input wire slpt_pkg::slpt_load_t    I_LIMIT_LOAD,
  input wire slpt_pkg::slpt_stk_req_t I_STK_REQ,
  input wire slpt_pkg::slpt_ea_req_t  I_EA_REQ,
  input wire logic [15:0]             O_SP,
  input wire logic [15:0]             O_LIMIT,
  input wire logic                    O_BUSY,
  input wire logic                    O_MEM_WE,
  input wire logic                    O_MEM_RE,
  input wire logic [15:0]             O_MEM_ADDR,
  input wire logic [15:0]             O_MEM_WDATA,
  input wire logic                    O_STACK_ERR,
  input wire logic                    O_STACK_UNDERFLOW,
  input wire logic                    O_EA_VALID,
  input wire logic                    O_EA_NEAR,
  input wire logic [23:0]             O_EA_ADDR,
  input wire logic                    O_ADDR_ERR
);
  ////////////////////////////////////////////////////////////////////////////
  // Request taken: pointer load and busy both lock the port out
  wire logic       take    = I_STK_REQ.valid && !I_SP_LOAD.valid && !O_BUSY;
  wire logic       push_in = take && I_STK_REQ.op == slpt_pkg::OP_PUSH;
  wire logic       pop_in  = take && I_STK_REQ.op == slpt_pkg::OP_POP;
  // Page picked by the access direction
  wire logic [8:0] ea_pg   = I_EA_REQ.is_write ? I_EA_REQ.write_page : I_EA_REQ.read_page;
  wire logic       ea_hi   = I_EA_REQ.valid && I_EA_REQ.addr >= slpt_pkg::PAGED_BASE;
  // Room for one or two words; an unloaded limit leaves these unknown, so load it first
  wire logic       room1   = O_SP >= slpt_pkg::UNDERFLOW_LIM && O_SP <= O_LIMIT;
  wire logic       room2   = room1 && O_SP + 16'h0002 <= O_LIMIT;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  ////////////////////////////////////////////////////////////////////////////
  AST_PUSH_DATA: assert property (push_in && I_STK_REQ.kind == slpt_pkg::KIND_DATA && room1 |=>
    O_MEM_WE && O_MEM_ADDR == $past(O_SP) && O_SP == $past(O_SP) + 16'h0002) else $error("data push wrong");
  AST_POP: assert property (pop_in && O_SP - 16'h0002 >= slpt_pkg::UNDERFLOW_LIM |=>
    O_MEM_RE && O_MEM_ADDR == O_SP && O_SP == $past(O_SP) - 16'h0002) else $error("pop wrong");
  AST_CALL_UPPER: assert property (push_in && I_STK_REQ.kind == slpt_pkg::KIND_CALL && room2 |=>
    O_BUSY ##1 (O_MEM_WE && O_MEM_WDATA == {8'h00, 1'b0, $past(I_STK_REQ.pc[22:16], 2)}))
    else $error("call upper word wrong");
  AST_EXC_UPPER: assert property (push_in && I_STK_REQ.kind == slpt_pkg::KIND_EXC && room2 |=>
    O_BUSY ##1 (O_MEM_WDATA == {$past(I_STK_REQ.status_low, 2), 1'b0, $past(I_STK_REQ.pc[22:16], 2)}
    && O_SP == $past(O_SP, 2) + 16'h0004)) else $error("exception upper word wrong");
  AST_LIMIT_WORD: assert property (I_LIMIT_LOAD.valid |=>
    O_LIMIT == {$past(I_LIMIT_LOAD.value[15:1]), 1'b0}) else $error("limit not word aligned");
  AST_OVERFLOW: assert property (push_in && O_SP > O_LIMIT |=>
    O_STACK_ERR && !O_MEM_WE && $stable(O_SP)) else $error("overflow push not trapped");
  AST_POP_FLOOR: assert property (pop_in && O_SP - 16'h0002 < slpt_pkg::UNDERFLOW_LIM |=>
    O_STACK_ERR && O_STACK_UNDERFLOW && !O_MEM_RE) else $error("underflow pop not trapped");
  AST_EA_NEAR: assert property (I_EA_REQ.valid && !ea_hi |=>
    O_EA_VALID && O_EA_NEAR && !O_ADDR_ERR && O_EA_ADDR == {8'h00, $past(I_EA_REQ.addr)}) else $error("near wrong");
  AST_EA_ERR: assert property (ea_hi && ea_pg == slpt_pkg::PAGE_NONE |=>
    O_ADDR_ERR && !O_EA_VALID) else $error("zero page not trapped");
  AST_EA_EXT: assert property (ea_hi && ea_pg != slpt_pkg::PAGE_NONE |=>
    O_EA_VALID && !O_EA_NEAR && O_EA_ADDR == {$past(ea_pg), $past(I_EA_REQ.addr[14:0])}) else $error("ext wrong");
  AST_EA_LIMIT: assert property (I_EA_REQ.valid && I_EA_REQ.uses_sp && I_EA_REQ.addr > O_LIMIT |=>
    O_STACK_ERR) else $error("pointer address past limit not trapped");
  AST_EA_FLOOR: assert property (I_EA_REQ.valid && I_EA_REQ.uses_sp && I_EA_REQ.addr < slpt_pkg::UNDERFLOW_LIM |=>
    O_STACK_ERR && O_STACK_UNDERFLOW) else $error("pointer address below floor not trapped");

  // Main scenarios reached
  COV_TRAP: cover property (push_in ##1 O_STACK_ERR);
  COV_BUSY: cover property (O_BUSY);
  COV_ADDR_ERR: cover property (O_ADDR_ERR);
endmodule // slpt_top_assertions

// *** dv/slpt_top_bench.sv ***
`timescale 1ns/10ps
module slpt_top_bench;
  logic                    clk;             // Core clock
  logic                    arst_n;          // Reset, active low
  slpt_pkg::slpt_load_t    sp_ld, lim_ld;   // Register loads
  slpt_pkg::slpt_stk_req_t stk;             // Stack request
  slpt_pkg::slpt_ea_req_t  ea;              // Address request
  logic [15:0]             sp, lim, maddr, wdata;
  logic                    busy, we, re, serr, sunf, eav, ean, aerr;
  logic [23:0]             eaa;
  logic [15:0]             sp_m;            // Expected pointer
  int                      bad_count, check_count;

  slpt_top i_slpt_top (.I_CLK(clk), .I_ARST_N(arst_n), .I_SP_LOAD(sp_ld), .I_LIMIT_LOAD(lim_ld),
    .I_STK_REQ(stk), .I_EA_REQ(ea), .O_SP(sp), .O_LIMIT(lim), .O_BUSY(busy), .O_MEM_WE(we),
    .O_MEM_RE(re), .O_MEM_ADDR(maddr), .O_MEM_WDATA(wdata), .O_STACK_ERR(serr),
    .O_STACK_UNDERFLOW(sunf), .O_EA_VALID(eav), .O_EA_NEAR(ean), .O_EA_ADDR(eaa), .O_ADDR_ERR(aerr));

  ////////////////////////////////////////////////////////////////////////////
  // Compares and verdict
  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expected page result: {error, 24-bit address}
  function automatic logic [24:0] ea_exp(input logic [15:0] a, input logic [8:0] pg);
    if (!a[15]) return {1'b0, 8'h00, a};
    return {pg == 9'h000, pg, a[14:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Drivers: one-cycle strobes, results sampled just after the taking edge
  task automatic load(input logic is_lim, input logic [15:0] v);
    @(posedge clk);
    if (is_lim) lim_ld <= '{valid: 1'b1, value: v};
    else sp_ld <= '{valid: 1'b1, value: v};
    @(posedge clk);
    lim_ld.valid <= 1'b0;
    sp_ld.valid <= 1'b0;
    #1;
  endtask
  task automatic stk_op(input logic op, input logic [1:0] k, input logic [15:0] d, input logic [22:0] pc,
                        input logic [7:0] sl);
    @(posedge clk);
    stk <= '{valid: 1'b1, op: slpt_pkg::slpt_op_t'(op), kind: slpt_pkg::slpt_kind_t'(k), data: d, pc: pc,
             status_low: sl};
    @(posedge clk);
    stk.valid <= 1'b0;
    #1;
  endtask
  // Trap suppresses the write and keeps the pointer
  task automatic push_chk(input logic [15:0] d, input logic ok, input logic unf);
    stk_op(1'b0, 2'h0, d, 23'h000000, 8'h00);
    chk_bit(we, ok, "push write");
    chk_bit(serr, !ok, "push trap");
    chk_bit(sunf, unf, "push underflow");
    if (ok) begin
      chk_word({8'h00, maddr}, {8'h00, sp_m}, "push address");
      chk_word({8'h00, wdata}, {8'h00, d}, "push data");
      sp_m = sp_m + 16'h0002;
    end
    chk_word({8'h00, sp}, {8'h00, sp_m}, "pointer");
  endtask
  task automatic pop_chk(input logic ok);
    stk_op(1'b1, 2'h0, 16'h0000, 23'h000000, 8'h00);
    chk_bit(re, ok, "pop read");
    chk_bit(sunf, !ok, "pop underflow");
    if (ok) sp_m = sp_m - 16'h0002;
    if (ok) chk_word({8'h00, maddr}, {8'h00, sp_m}, "pop address");
    chk_word({8'h00, sp}, {8'h00, sp_m}, "pointer");
  endtask
  // Counter push: low word, then upper word one cycle later
  task automatic cpush(input logic [1:0] k, input logic [22:0] pc, input logic [7:0] sl);
    stk_op(1'b0, k, 16'h0000, pc, sl);
    chk_bit(busy, 1'b1, "busy");
    chk_word({8'h00, wdata}, {8'h00, pc[15:0]}, "low word");
    @(posedge clk);
    #1;
    chk_bit(we, 1'b1, "upper write");
    chk_word({8'h00, maddr}, {8'h00, sp_m + 16'h0002}, "upper address");
    chk_word({8'h00, wdata}, {8'h00, (k == 2'h2) ? sl : 8'h00, 1'b0, pc[22:16]}, "upper word");
    sp_m = sp_m + 16'h0004;
    chk_word({8'h00, sp}, {8'h00, sp_m}, "pointer");
  endtask
  task automatic ea_chk(input logic wr, input logic use_sp, input logic [15:0] a, input logic [8:0] rp,
                        input logic [8:0] wp, input logic exp_serr);
    logic [24:0] e;
    e = ea_exp(a, wr ? wp : rp);
    @(posedge clk);
    ea <= '{valid: 1'b1, is_write: wr, uses_sp: use_sp, addr: a, read_page: rp, write_page: wp};
    @(posedge clk);
    ea.valid <= 1'b0;
    #1;
    chk_bit(aerr, e[24], "address trap");
    chk_bit(eav, !e[24], "address valid");
    chk_bit(serr, exp_serr, "pointer address trap");
    if (!e[24]) chk_bit(ean, !a[15], "near");
    if (!e[24]) chk_word(eaa, e[23:0], "extended address");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog far beyond the about 135 cycles the run needs
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict();
  end
  initial begin
    logic [8:0] rp;
    logic [8:0] wp;
    void'($urandom(33));
    arst_n = 1'b0;
    sp_ld = '0;
    lim_ld = '0;
    stk = '0;
    ea = '0;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk_word({8'h00, sp}, 24'h000800, "reset pointer");
    load(1'b1, 16'h080B);
    chk_word({8'h00, lim}, 24'h00080A, "limit");
    sp_m = 16'h0800;
    for (int i = 0; i < 6; i++) push_chk(16'($urandom), 1'b1, 1'b0);
    push_chk(16'($urandom), 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) pop_chk(1'b1);
    pop_chk(1'b0);
    cpush(2'h1, 23'($urandom), 8'($urandom));
    cpush(2'h2, 23'($urandom), 8'($urandom));
    load(1'b0, 16'h0400);
    sp_m = 16'h0400;
    push_chk(16'($urandom), 1'b0, 1'b1);
    ea_chk(1'b0, 1'b0, 16'h7FFF, 9'h000, 9'h000, 1'b0);
    ea_chk(1'b0, 1'b0, 16'h9234, 9'h002, 9'h000, 1'b0);
    ea_chk(1'b1, 1'b0, 16'h8000, 9'h1FF, 9'h000, 1'b0);
    ea_chk(1'b0, 1'b1, 16'h0900, 9'h000, 9'h000, 1'b1);
    ea_chk(1'b0, 1'b1, 16'h0700, 9'h000, 9'h000, 1'b1);
    for (int i = 0; i < 40; i++) begin
      rp = ($urandom_range(3) == 0) ? 9'h000 : 9'($urandom);
      wp = ($urandom_range(3) == 0) ? 9'h000 : 9'($urandom);
      ea_chk(1'($urandom), 1'b0, 16'($urandom), rp, wp, 1'b0);
    end
    give_verdict();
  end
endmodule // slpt_top_bench

bind slpt_top slpt_top_assertions i_slpt_top_assertions (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
  .I_SP_LOAD(I_SP_LOAD), .I_LIMIT_LOAD(I_LIMIT_LOAD), .I_STK_REQ(I_STK_REQ), .I_EA_REQ(I_EA_REQ),
  .O_SP(O_SP), .O_LIMIT(O_LIMIT), .O_BUSY(O_BUSY), .O_MEM_WE(O_MEM_WE), .O_MEM_RE(O_MEM_RE),
  .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .O_STACK_ERR(O_STACK_ERR),
  .O_STACK_UNDERFLOW(O_STACK_UNDERFLOW), .O_EA_VALID(O_EA_VALID), .O_EA_NEAR(O_EA_NEAR),
  .O_EA_ADDR(O_EA_ADDR), .O_ADDR_ERR(O_ADDR_ERR));
